// ===== hdl/modem_cfg_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the
  modem frequency and diversity configuration bank.
  Assumes an 8-bit register port with 7-bit addresses.
*/
`ifndef MODEM_CFG_CFG_SVH
`define MODEM_CFG_CFG_SVH

// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define OFS_LEVEL2_HOLD 7'h3e
`define OFS_LEVEL1_HOLD 7'h3f
`define OFS_CARRIER_HOLD 7'h40
`define OFS_SYMBOL_MAP 7'h41
`define OFS_FINE_HIGH 7'h42
`define OFS_FINE_LOW 7'h43
`define OFS_GAP_FIRST 7'h44
`define OFS_GAP_LAST 7'h47
`define OFS_DIV_MODE 7'h48
`define OFS_SEARCH_FIRST 7'h49
`define OFS_SEARCH_SECOND 7'h4a
`define OFS_LEVEL4_HOLD 7'h3c
`define OFS_LEVEL3_HOLD 7'h3d
`define OFS_SEARCH_CTRL 7'h60
`define OFS_SEARCH_STAT 7'h61

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_HOLD 7'h2d
`define RST_SYMBOL_MAP 8'he1
`define RST_FINE 8'h00
`define RST_AVG 3'h1
`define RST_FAST 1'b0
`define RST_RES 1'b1
`define RST_SEARCH 7'h0e

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_FINE_DIR 7
`define BIT_FAST_MODE 4
`define BIT_SEARCH_RES 7

// ----------------------------------------------------------------
// timing: resolution steps at 200 MHz
// ----------------------------------------------------------------
`define CLK_MHZ 200
`define STEP_FINE_US 16
`define STEP_COARSE_US 256
`define STEP_FINE_CYC (`STEP_FINE_US * `CLK_MHZ)
`define STEP_COARSE_CYC (`STEP_COARSE_US * `CLK_MHZ)

`endif

// ===== hdl/modem_cfg_pkg.sv
/*
  Types of the modem configuration bank.
  Assumes the constants header is compiled alongside.
*/
package modem_cfg_pkg;
  typedef struct packed {
    logic [6:0] top_level;
    logic [6:0] third_level;
    logic [6:0] second_level;
    logic [6:0] bottom_level;
    logic [6:0] carrier;
  } hold_times_t;

  typedef struct packed {
    logic [1:0] symbol_for_top_level;
    logic [1:0] symbol_for_third_level;
    logic [1:0] symbol_for_second_level;
    logic [1:0] symbol_for_bottom_level;
  } symbol_map_t;

  typedef struct packed {
    logic fine_offset_direction;
    logic [9:0] fine_offset_magnitude;
  } fine_offset_t;

  typedef struct packed {
    logic fast_enable;
    logic [2:0] energy_average_count;
    logic coarse_res;
    logic [6:0] first_search_count;
    logic [6:0] second_search_count;
  } diversity_t;

  typedef enum logic [1:0] {
    SRCH_IDLE,
    SRCH_FIRST,
    SRCH_SECOND
  } search_state_t;
endpackage : modem_cfg_pkg

// ===== hdl/search_timer.sv
/*
  Search duration timer: counts a 7-bit count times a resolution step.
  Assumes start is a one-cycle pulse on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "modem_cfg_cfg.svh"
module search_timer
  import modem_cfg_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic coarse,
  input wire logic [6:0] count,
  output logic busy,
  output logic done
);
  localparam logic [15:0] FINE_CYC = 16'(`STEP_FINE_CYC);
  localparam logic [15:0] COARSE_CYC = 16'(`STEP_COARSE_CYC);

  logic [15:0] step_r;
  logic [6:0] left_r;
  logic busy_r;
  logic done_r;
  logic [15:0] step_len;
  logic step_end;

  assign step_len = coarse ? COARSE_CYC : FINE_CYC;
  assign step_end = (step_r == step_len - 16'h0001);

  // duration = count x step; a zero count ends at once
  always_ff @(posedge clk or negedge rst_b) begin // R11
    if (!rst_b) begin
      step_r <= 16'h0000;
      left_r <= 7'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        step_r <= 16'h0000;
        left_r <= count;
        busy_r <= (count != 7'h00);
        done_r <= (count == 7'h00);
      end else if (busy_r) begin
        step_r <= step_end ? 16'h0000 : step_r + 16'h0001;
        if (step_end) begin
          left_r <= left_r - 7'h01;
          if (left_r == 7'h01) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
      end
    end
  end

  assign busy = busy_r;
  assign done = done_r;
endmodule // search_timer
`default_nettype wire

// ===== hdl/modem_freq_diversity_cfg.sv
/*
  Register bank for deviation hold times, four-level symbol map, fine
  frequency offset and antenna diversity settings, plus a search timer.
  Assumes a synchronous 8-bit register port on MCLK; read data one
  cycle after the read strobe.
*/
// The address-and-strobe port is this design's own decision.
// Behaviour
// R1 - five 7-bit hold times, reset 0x2d
// R2 - bits 7:6 map top level, reset 11
// R3 - bits 1:0 map bottom level, reset 01
// R4 - map register resets 0xe1, middle fields
// R5 - high bit 7: 0 down, 1 up
// R6 - 10-bit magnitude across high, low registers
// R7 - mode bit 4 enables fast search
// R8 - 3-bit energy average count, reset 001
// R9 - search bit 7: 16 or 256 us
// R10 - two 7-bit search counts, reset 0x0e
// R11 - search time = count times step
`timescale 1ns/10ps
`default_nettype none
`include "modem_cfg_cfg.svh"
module modem_freq_diversity_cfg
  import modem_cfg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic [6:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output hold_times_t HOLD_TIMES,
  output symbol_map_t SYMBOL_MAP,
  output fine_offset_t FINE_OFFSET,
  output diversity_t DIVERSITY,
  output logic SEARCH_BUSY,
  output logic SEARCH_DONE
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [6:0] hold_r [5];
  logic [7:0] map_r;
  logic dir_r;
  logic [9:0] mag_r;
  logic fast_r;
  logic [2:0] avg_r;
  logic res_r;
  logic [6:0] srch1_r;
  logic [6:0] srch2_r;
  logic done_seen_r;
  logic [7:0] rdata_nxt;
  search_state_t state_r;
  search_state_t state_nxt;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic [6:0] hold_ofs [5];
  assign hold_ofs[0] = `OFS_LEVEL4_HOLD;
  assign hold_ofs[1] = `OFS_LEVEL3_HOLD;
  assign hold_ofs[2] = `OFS_LEVEL2_HOLD;
  assign hold_ofs[3] = `OFS_LEVEL1_HOLD;
  assign hold_ofs[4] = `OFS_CARRIER_HOLD;
  wire logic wr_map = WR && (ADDR == `OFS_SYMBOL_MAP);
  wire logic wr_high = WR && (ADDR == `OFS_FINE_HIGH);
  wire logic wr_low = WR && (ADDR == `OFS_FINE_LOW);
  wire logic wr_mode = WR && (ADDR == `OFS_DIV_MODE);
  wire logic wr_s1 = WR && (ADDR == `OFS_SEARCH_FIRST);
  wire logic wr_s2 = WR && (ADDR == `OFS_SEARCH_SECOND);
  wire logic wr_ctrl = WR && (ADDR == `OFS_SEARCH_CTRL);
  wire logic rd_stat = RD && (ADDR == `OFS_SEARCH_STAT);
  wire logic start_req = wr_ctrl && WDATA[0];

  // ----------------------------------------------------------------
  // hold times, one per level and carrier
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_hold
      always_ff @(posedge MCLK or negedge RST_B) begin
        if (!RST_B) begin
          hold_r[gi] <= `RST_HOLD; // R1
        end else if (WR && ADDR == hold_ofs[gi]) begin
          hold_r[gi] <= WDATA[6:0]; // R1
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // map, fine offset and diversity fields
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      map_r <= `RST_SYMBOL_MAP; // R4
      dir_r <= 1'b0; // R5
      mag_r <= {2'b00, `RST_FINE}; // R6
    end else begin
      if (wr_map) map_r <= WDATA; // R2 R3 R4
      if (wr_high) begin
        dir_r <= WDATA[`BIT_FINE_DIR]; // R5
        mag_r[9:8] <= WDATA[1:0]; // R6
      end
      if (wr_low) mag_r[7:0] <= WDATA; // R6
    end
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      fast_r <= `RST_FAST; // R7
      avg_r <= `RST_AVG; // R8
      res_r <= `RST_RES; // R9
      srch1_r <= `RST_SEARCH; // R10
      srch2_r <= `RST_SEARCH; // R10
    end else begin
      if (wr_mode) begin
        fast_r <= WDATA[`BIT_FAST_MODE]; // R7
        avg_r <= WDATA[2:0]; // R8
      end
      if (wr_s1) begin
        res_r <= WDATA[`BIT_SEARCH_RES]; // R9
        srch1_r <= WDATA[6:0]; // R10
      end
      if (wr_s2) srch2_r <= WDATA[6:0]; // R10
    end
  end

  // ----------------------------------------------------------------
  // search sequencer: first window, then second
  // ----------------------------------------------------------------
  wire logic tmr_busy;
  wire logic tmr_done;
  wire logic tmr_start = (state_r == SRCH_IDLE && start_req) ||
                         (state_r == SRCH_FIRST && tmr_done);
  wire logic [6:0] tmr_count = (state_r == SRCH_IDLE) ? srch1_r : srch2_r;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SRCH_IDLE: if (start_req) state_nxt = SRCH_FIRST;
      SRCH_FIRST: if (tmr_done) state_nxt = SRCH_SECOND;
      SRCH_SECOND: if (tmr_done) state_nxt = SRCH_IDLE;
      default: state_nxt = SRCH_IDLE;
    endcase
  end

  search_timer u_timer (
    .clk(MCLK),
    .rst_b(RST_B),
    .start(tmr_start),
    .coarse(res_r), // R9
    .count(tmr_count), // R11
    .busy(tmr_busy),
    .done(tmr_done)
  );

  wire logic all_done = (state_r == SRCH_SECOND) && tmr_done;

  // sticky done; a finish in the read cycle wins over the clear
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state_r <= SRCH_IDLE;
      done_seen_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_seen_r <= all_done | (done_seen_r & ~rd_stat);
    end
  end

  // ----------------------------------------------------------------
  // read mux; reserved bits and unmapped addresses read zero
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    case (ADDR)
      `OFS_LEVEL4_HOLD: rdata_nxt = {1'b0, hold_r[0]};
      `OFS_LEVEL3_HOLD: rdata_nxt = {1'b0, hold_r[1]};
      `OFS_LEVEL2_HOLD: rdata_nxt = {1'b0, hold_r[2]};
      `OFS_LEVEL1_HOLD: rdata_nxt = {1'b0, hold_r[3]};
      `OFS_CARRIER_HOLD: rdata_nxt = {1'b0, hold_r[4]};
      `OFS_SYMBOL_MAP: rdata_nxt = map_r;
      `OFS_FINE_HIGH: rdata_nxt = {dir_r, 5'h00, mag_r[9:8]};
      `OFS_FINE_LOW: rdata_nxt = mag_r[7:0];
      `OFS_DIV_MODE: rdata_nxt = {3'h0, fast_r, 1'b0, avg_r};
      `OFS_SEARCH_FIRST: rdata_nxt = {res_r, srch1_r};
      `OFS_SEARCH_SECOND: rdata_nxt = {1'b0, srch2_r};
      `OFS_SEARCH_STAT: rdata_nxt = {4'h0, state_r, done_seen_r, tmr_busy};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      RDATA <= 8'h00;
      HOLD_TIMES <= '0;
      SYMBOL_MAP <= '0;
      FINE_OFFSET <= '0;
      DIVERSITY <= '0;
      SEARCH_BUSY <= 1'b0;
      SEARCH_DONE <= 1'b0;
    end else begin
      RDATA <= RD ? rdata_nxt : 8'h00;
      HOLD_TIMES <= {hold_r[0], hold_r[1], hold_r[2], hold_r[3], hold_r[4]};
      SYMBOL_MAP <= map_r;
      FINE_OFFSET <= {dir_r, mag_r};
      DIVERSITY <= {fast_r, avg_r, res_r, srch1_r, srch2_r};
      SEARCH_BUSY <= (state_r != SRCH_IDLE);
      SEARCH_DONE <= all_done;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_HOLD_WRITE: assert property (@(posedge MCLK) disable iff (!RST_B) // R1
    WR && ADDR == `OFS_CARRIER_HOLD |=> ##1 HOLD_TIMES.carrier == $past(WDATA[6:0], 2))
    else $error("carrier hold time not written");
  AST_MAP_TOP: assert property (@(posedge MCLK) disable iff (!RST_B) // R2
    wr_map |=> ##1 SYMBOL_MAP.symbol_for_top_level == $past(WDATA[7:6], 2))
    else $error("top level symbol wrong");
  AST_MAP_BOTTOM: assert property (@(posedge MCLK) disable iff (!RST_B) // R3
    wr_map |=> ##1 SYMBOL_MAP.symbol_for_bottom_level == $past(WDATA[1:0], 2))
    else $error("bottom level symbol wrong");
  AST_MAP_READ: assert property (@(posedge MCLK) disable iff (!RST_B) // R4
    RD && ADDR == `OFS_SYMBOL_MAP |=> RDATA == SYMBOL_MAP || $past(wr_map))
    else $error("map readback mismatch");
  AST_DIR: assert property (@(posedge MCLK) disable iff (!RST_B) // R5
    wr_high |=> ##1 FINE_OFFSET.fine_offset_direction == $past(WDATA[7], 2))
    else $error("fine offset direction wrong");
  AST_MAG: assert property (@(posedge MCLK) disable iff (!RST_B) // R6
    wr_low |=> ##1 FINE_OFFSET.fine_offset_magnitude[7:0] == $past(WDATA, 2))
    else $error("fine offset low byte wrong");
  AST_FAST: assert property (@(posedge MCLK) disable iff (!RST_B) // R7
    wr_mode |=> ##1 DIVERSITY.fast_enable == $past(WDATA[4], 2))
    else $error("fast mode bit wrong");
  AST_AVG: assert property (@(posedge MCLK) disable iff (!RST_B) // R8
    wr_mode |=> ##1 DIVERSITY.energy_average_count == $past(WDATA[2:0], 2))
    else $error("average count wrong");
  AST_RES: assert property (@(posedge MCLK) disable iff (!RST_B) // R9
    wr_s1 |=> ##1 DIVERSITY.coarse_res == $past(WDATA[7], 2))
    else $error("search resolution wrong");
  AST_SRCH2: assert property (@(posedge MCLK) disable iff (!RST_B) // R10
    wr_s2 |=> ##1 DIVERSITY.second_search_count == $past(WDATA[6:0], 2))
    else $error("second search count wrong");
  AST_ZERO_SEARCH: assert property (@(posedge MCLK) disable iff (!RST_B) // R11
    state_r == SRCH_IDLE && start_req && srch1_r == 7'h00 && srch2_r == 7'h00
    |=> ##1 all_done)
    else $error("zero-length search did not end in two cycles");

  // ----------------------------------------------------------------
  // checks: middle map fields, high magnitude bits, first count
  // ----------------------------------------------------------------
  AST_MAP_THIRD: assert property (@(posedge MCLK) disable iff (!RST_B) // R4
    wr_map |=> ##1 SYMBOL_MAP.symbol_for_third_level == $past(WDATA[5:4], 2))
    else $error("third level symbol wrong");
  AST_MAP_SECOND: assert property (@(posedge MCLK) disable iff (!RST_B) // R4
    wr_map |=> ##1 SYMBOL_MAP.symbol_for_second_level == $past(WDATA[3:2], 2))
    else $error("second level symbol wrong");
  AST_MAG_HIGH: assert property (@(posedge MCLK) disable iff (!RST_B) // R6
    wr_high |=> ##1 FINE_OFFSET.fine_offset_magnitude[9:8] == $past(WDATA[1:0], 2))
    else $error("fine offset high bits wrong");
  AST_SRCH1: assert property (@(posedge MCLK) disable iff (!RST_B) // R10
    wr_s1 |=> ##1 DIVERSITY.first_search_count == $past(WDATA[6:0], 2))
    else $error("first search count wrong");

  // ----------------------------------------------------------------
  // checks: reserved bits read zero, fields hold between writes
  // ----------------------------------------------------------------
  AST_HOLD_RSVD: assert property (@(posedge MCLK) disable iff (!RST_B) // R1
    RD && ADDR == `OFS_CARRIER_HOLD |=> RDATA[7] == 1'b0)
    else $error("hold time reserved bit not zero");
  AST_FINE_RSVD: assert property (@(posedge MCLK) disable iff (!RST_B) // R5
    RD && ADDR == `OFS_FINE_HIGH |=> RDATA[6:2] == 5'h00)
    else $error("fine offset reserved bits not zero");
  AST_MODE_RSVD: assert property (@(posedge MCLK) disable iff (!RST_B) // R7
    RD && ADDR == `OFS_DIV_MODE |=> RDATA[7:5] == 3'h0 && RDATA[3] == 1'b0)
    else $error("mode reserved bits not zero");
  AST_SRCH2_RSVD: assert property (@(posedge MCLK) disable iff (!RST_B) // R10
    RD && ADDR == `OFS_SEARCH_SECOND |=> RDATA[7] == 1'b0)
    else $error("second search reserved bit not zero");
  AST_MAP_KEEP: assert property (@(posedge MCLK) disable iff (!RST_B) // R4
    !wr_map |=> $stable(map_r))
    else $error("map changed without a write");
  AST_FINE_KEEP: assert property (@(posedge MCLK) disable iff (!RST_B) // R6
    !wr_high && !wr_low |=> $stable(mag_r) && $stable(dir_r))
    else $error("fine offset changed without a write");
  AST_SRCH_KEEP: assert property (@(posedge MCLK) disable iff (!RST_B) // R10
    !wr_s1 && !wr_s2 |=> $stable(srch1_r) && $stable(srch2_r) && $stable(res_r))
    else $error("search settings changed without a write");

  // ----------------------------------------------------------------
  // checks: search sequencer
  // ----------------------------------------------------------------
  AST_SEARCH_BUSY: assert property (@(posedge MCLK) disable iff (!RST_B) // R11
    state_r == SRCH_IDLE && start_req |=> ##1 SEARCH_BUSY)
    else $error("search busy not raised after start");
  AST_DONE_PULSE: assert property (@(posedge MCLK) disable iff (!RST_B) // R11
    SEARCH_DONE |=> SEARCH_DONE == 1'b0)
    else $error("search done longer than one cycle");
  // set must win over a status read in the same cycle
  AST_STICKY: assert property (@(posedge MCLK) disable iff (!RST_B) // R11
    all_done |=> done_seen_r)
    else $error("sticky done not set");

  CVR_SEARCH_END: cover property (@(posedge MCLK) disable iff (!RST_B) all_done);
  CVR_MAP_WRITE: cover property (@(posedge MCLK) disable iff (!RST_B) wr_map);
  CVR_STAT_CLEAR: cover property (@(posedge MCLK) disable iff (!RST_B)
    rd_stat && done_seen_r);
  CVR_COARSE_RUN: cover property (@(posedge MCLK) disable iff (!RST_B)
    tmr_busy && res_r);
  CVR_FAST_ON: cover property (@(posedge MCLK) disable iff (!RST_B)
    wr_mode && WDATA[`BIT_FAST_MODE]);
endmodule // modem_freq_diversity_cfg
`default_nettype wire

// ===== tb/tb.sv
/*
  Self-checking bench of the modem frequency and diversity register bank.
  Assumes the package and constants header are compiled first; drives the
  register port directly, with no partner model.
*/
`timescale 1ns/10ps
`default_nettype none
`include "modem_cfg_cfg.svh"
module tb
  import modem_cfg_pkg::*;
;
  logic mclk;
  logic rst_b;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic wr_s;
  logic rd_s;
  logic [7:0] rdata;
  hold_times_t hold_times;
  symbol_map_t symbol_map;
  fine_offset_t fine_offset;
  diversity_t diversity;
  logic search_busy;
  logic search_done;
  int fails;
  int n_tests;
  logic [7:0] sh [0:127];
  logic [7:0] d;

  modem_freq_diversity_cfg u_modem_freq_diversity_cfg (
    .MCLK(mclk),
    .RST_B(rst_b),
    .ADDR(addr),
    .WDATA(wdata),
    .WR(wr_s),
    .RD(rd_s),
    .RDATA(rdata),
    .HOLD_TIMES(hold_times),
    .SYMBOL_MAP(symbol_map),
    .FINE_OFFSET(fine_offset),
    .DIVERSITY(diversity),
    .SEARCH_BUSY(search_busy),
    .SEARCH_DONE(search_done)
  );

  always #2.5 mclk = ~mclk;

  // ----------------------------------------------------------------
  // expectations
  // ----------------------------------------------------------------
  // unmapped and gap addresses keep nothing, so their mask is zero
  function automatic logic [7:0] msk(input logic [6:0] a);
    case (a)
      7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h40, 7'h4a: msk = 8'h7f;
      7'h41, 7'h43, 7'h49: msk = 8'hff;
      7'h42: msk = 8'h83;
      7'h48: msk = 8'h17;
      default: msk = 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] rst_val(input logic [6:0] a);
    case (a)
      7'h3c, 7'h3d, 7'h3e, 7'h3f, 7'h40: rst_val = 8'h2d;
      7'h41: rst_val = 8'he1;
      7'h48: rst_val = 8'h01;
      7'h49: rst_val = 8'h8e;
      7'h4a: rst_val = 8'h0e;
      default: rst_val = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one gap cycle after each strobe keeps a driver from assigning twice
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    sh[a] = v & msk(a);
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic chk_all();
    for (int a = 8'h3a; a <= 8'h4c; a++) begin
      rd(a[6:0], d);
      chk(d, sh[a]);
    end
    repeat (2) @(posedge mclk);
    #1;
    chk(hold_times, {sh[8'h3c][6:0], sh[8'h3d][6:0], sh[8'h3e][6:0],
      sh[8'h3f][6:0], sh[8'h40][6:0]});
    chk(symbol_map, sh[8'h41]);
    chk(fine_offset, {sh[8'h42][7], sh[8'h42][1:0], sh[8'h43]});
    chk(diversity, {sh[8'h48][4], sh[8'h48][2:0], sh[8'h49][7], sh[8'h49][6:0],
      sh[8'h4a][6:0]});
  endtask

  // lo is the bare length of both windows together; the design adds a few cycles of overhead
  task automatic srch(input logic [7:0] s1, input logic [7:0] s2, input int lo);
    int n;
    wr(`OFS_SEARCH_FIRST, s1);
    wr(`OFS_SEARCH_SECOND, s2);
    wr(`OFS_SEARCH_CTRL, 8'h01);
    n = 0;
    #1;
    while (search_done !== 1'b1 && n < lo + 20) begin
      @(posedge mclk);
      #1;
      n++;
      if (n == lo / 2 && lo > 100) begin
        chk(search_busy, 1'b1);
      end
    end
    if (search_done !== 1'b1) begin
      fails++;
      $display("[ERR] %0t search never finished", $time);
      summarize();
    end
    chk(n >= lo && n <= lo + 10, 1'b1);
    rd(`OFS_SEARCH_STAT, d);
    chk(d, 8'h02);
    rd(`OFS_SEARCH_STAT, d);
    chk(d, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    rst_b = 1'b0;
    addr = 7'h00;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    fails = 0;
    n_tests = 0;
    void'($urandom(61948));
    for (int a = 0; a < 128; a++) begin
      sh[a] = rst_val(a[6:0]);
    end
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    chk_all();
    // all ones and all zeros first, then random fills
    for (int r = 0; r < 5; r++) begin
      for (int a = 8'h3a; a <= 8'h4c; a++) begin
        wr(a[6:0], r == 0 ? 8'hff : r == 1 ? 8'h00 : 8'($urandom));
      end
      wr(7'h10, 8'($urandom));
      rd(7'h10, d);
      chk(d, 8'h00);
      chk_all();
    end
    // mid-run reset: every field must fall back after random fills
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    for (int a = 0; a < 128; a++) begin
      sh[a] = rst_val(a[6:0]);
    end
    chk_all();
    for (int c = 0; c < 6; c++) begin
      wr(`OFS_DIV_MODE, {3'h0, c[0], 1'b0, c[2:0]});
      repeat (2) @(posedge mclk);
      #1;
      chk(diversity.energy_average_count, c[2:0]);
      chk(diversity.fast_enable, c[0]);
    end
    srch(8'h00, 8'h00, 0);
    srch(8'h01, 8'h01, 2 * `STEP_FINE_CYC);
    srch(8'h81, 8'h00, `STEP_COARSE_CYC);
    summarize();
  end
endmodule // tb
`default_nettype wire
